// file: dcae_regs.svh
// register offsets, reset values and timing counts of the dma addressing engine
// assumes a 7-bit byte address on the avalon-mm slave port
`ifndef DCAE_REGS_SVH
`define DCAE_REGS_SVH
`define DCAE_CH_SEL_HI  6
`define DCAE_CH_SEL_LO  4
`define DCAE_REG_CTL    2'h0
`define DCAE_REG_SRC    2'h1
`define DCAE_REG_DST    2'h2
`define DCAE_REG_SIZE   2'h3
`define DCAE_GLB_BASE   3'h4
`define DCAE_GLB_STAT   2'h0
`define DCAE_GLB_CLR    2'h1
`define DCAE_GLB_IE     2'h2
`define DCAE_GLB_CFG    2'h3
`define DCAE_CTL_W      11
`define DCAE_CTL_RST    11'h000
`define DCAE_IE_RST     1'b0
`define DCAE_CFG_RR_BIT 0
`define DCAE_CFG_BUSY   1
`define DCAE_BURST_LEN  2'h3
`define DCAE_GAP_CYC    2
`endif

// file: dcae_pkg.sv
// types shared by the dma addressing engine
// assumes nothing beyond a systemverilog compiler
package dcae_pkg;
	typedef enum logic [1:0] {MODE_SINGLE, MODE_BLOCK, MODE_BURST, MODE_RSVD} dcae_mode_t;
	typedef enum logic [1:0] {STEP_HOLD, STEP_INC, STEP_DEC, STEP_RSVD} dcae_step_t;
	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_GAP} dcae_fsm_t;
	typedef struct packed {
		logic       level;
		logic       dstByte;
		logic       srcByte;
		dcae_step_t dstStep;
		dcae_step_t srcStep;
		logic       repeatEn;
		dcae_mode_t mode;
		logic       enable;
	} dcae_ctl_t;
	typedef struct packed {
		dcae_ctl_t   ctl;
		logic [15:0] srcCfg;
		logic [15:0] dstCfg;
		logic [15:0] size;
		logic [15:0] srcWork;
		logic [15:0] dstWork;
		logic [15:0] cntWork;
		logic        pend;
		logic        blockAct;
		logic        trigPrev;
	} dcae_chan_t;
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic        rd;
		logic        wr;
		logic        byteAcc;
	} dcae_mem_t;
endpackage

// file: dcae_engine.sv
// multi-channel dma addressing engine with avalon-mm register slave
// assumes a memory bus answering reads combinationally in the same cycle,
// byte reads returned in the low eight bits, and same-clock trigger inputs
// Overview of operation
// - copy source to destination without processor help
// - one to three independent channels
// - each item takes a read and write cycle
// - transfer count up to 65535 items
// - fixed or rotating channel priority
// - trigger by rising edge or level
// - single, block and burst-block modes
// - nine address patterns, chosen per channel
// - source address steps up, down or holds
// - destination address steps up, down or holds
// - byte or word on each side
// - word to byte writes low byte only
// - byte to word clears upper byte
// - zero count performs no transfers
// - count reaching zero reloads and flags done
`include "dcae_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module dcae_engine
	import dcae_pkg::*;
#(
	parameter int NCH = 3
) (
	input  wire logic              clk,             // system clock
	input  wire logic              reset,           // synchronous reset
	input  wire logic [6:0]        avs_address,     // register byte address
	input  wire logic              avs_read,        // register read
	input  wire logic              avs_write,       // register write
	input  wire logic [31:0]       avs_writedata,   // register write data
	output logic [31:0]            avs_readdata,    // register read data
	output logic                   avs_waitrequest, // slave stall
	input  wire logic [NCH-1:0]    trig,            // channel triggers
	input  wire logic [15:0]       memRdata,        // memory read data
	output dcae_mem_t              mem,             // memory request
	output logic                   busOwn,          // engine holds the bus
	output logic                   irq              // level interrupt
);
	typedef struct packed {
		dcae_chan_t [NCH-1:0] ch;
		dcae_fsm_t            fsm;
		logic [1:0]           cur;
		logic [1:0]           last;
		logic [1:0]           burstCnt;
		logic [1:0]           gapCnt;
		dcae_mem_t            mem;
		logic [NCH-1:0]       ifg;
		logic [NCH-1:0]       ie;
		logic                 rrEn;
		logic                 ack;
		logic [31:0]          rdata;
	} dcae_state_t;

	dcae_state_t    st_ff;
	dcae_state_t    nxt_st;
	logic [NCH-1:0] elig;
	logic [NCH-1:0] ifgSet;
	logic [NCH-1:0] ifgClr;
	logic [1:0]     sel;
	logic [1:0]     rIdx;
	logic [1:0]     ci;
	logic           lastItem;
	logic           cont;
	logic [15:0]    fmtData;

	function automatic logic chanHit(input logic [6:0] a);
		chanHit = (int'(a[`DCAE_CH_SEL_HI:`DCAE_CH_SEL_LO]) < NCH);
	endfunction

	function automatic logic [1:0] pickChan(input logic [NCH-1:0] req, input logic [1:0] prev,
		input logic rr);
		logic [1:0] idx;
		logic       found;
		pickChan = 2'h0;
		found = 1'b0;
		for (int k = 0; k < NCH; k++) begin
			idx = rr ? 2'((int'(prev) + 1 + k) % NCH) : 2'(k);
			if (!found && req[idx]) begin
				pickChan = idx;
				found = 1'b1;
			end
		end
	endfunction

	function automatic logic [15:0] stepAddr(input logic [15:0] a, input dcae_step_t s, input logic isByte);
		logic [15:0] d;
		d = isByte ? 16'h0001 : 16'h0002;
		case (s)
			STEP_INC: stepAddr = a + d;
			STEP_DEC: stepAddr = a - d;
			default:  stepAddr = a;
		endcase
	endfunction

	assign avs_waitrequest = (avs_read || avs_write) && !st_ff.ack;
	assign avs_readdata = st_ff.rdata;
	assign mem = st_ff.mem;
	assign busOwn = (st_ff.fsm == ST_READ) || (st_ff.fsm == ST_WRITE);
	assign irq = |(st_ff.ifg & st_ff.ie);

	always_comb begin
		nxt_st = st_ff;
		elig = '0;
		ifgSet = '0;
		ifgClr = '0;
		sel = 2'h0;
		rIdx = avs_address[3:2];
		ci = avs_address[5:4];
		lastItem = 1'b0;
		cont = 1'b0;
		fmtData = 16'h0000;
		nxt_st.ack = 1'b0;
		// trigger capture and eligibility, one per channel
		for (int i = 0; i < NCH; i++) begin
			if (!st_ff.ch[i].ctl.level && trig[i] && !st_ff.ch[i].trigPrev &&
				st_ff.ch[i].ctl.enable && !st_ff.ch[i].blockAct) begin
				nxt_st.ch[i].pend = 1'b1;
			end
			nxt_st.ch[i].trigPrev = trig[i];
			elig[i] = st_ff.ch[i].ctl.enable && (st_ff.ch[i].size != 16'h0000) &&
				(st_ff.ch[i].blockAct || st_ff.ch[i].pend || (st_ff.ch[i].ctl.level && trig[i]));
		end
		case (st_ff.fsm)
			ST_IDLE: begin
				if (|elig) begin
					sel = pickChan(elig, st_ff.last, st_ff.rrEn);
					nxt_st.cur = sel;
					nxt_st.last = sel;
					nxt_st.burstCnt = 2'h0;
					nxt_st.ch[sel].pend = 1'b0;
					if (st_ff.ch[sel].ctl.mode != MODE_SINGLE) begin
						nxt_st.ch[sel].blockAct = 1'b1;
					end
					nxt_st.fsm = ST_READ;
					nxt_st.mem.rd = 1'b1;
					nxt_st.mem.addr = st_ff.ch[sel].srcWork;
					nxt_st.mem.byteAcc = st_ff.ch[sel].ctl.srcByte;
				end
			end
			ST_READ: begin
				// width conversion between the two sides
				fmtData = st_ff.ch[st_ff.cur].ctl.srcByte ? {8'h00, memRdata[7:0]} : memRdata;
				nxt_st.mem.rd = 1'b0;
				nxt_st.mem.wr = 1'b1;
				nxt_st.mem.addr = st_ff.ch[st_ff.cur].dstWork;
				nxt_st.mem.wdata = fmtData;
				nxt_st.mem.byteAcc = st_ff.ch[st_ff.cur].ctl.dstByte;
				nxt_st.fsm = ST_WRITE;
			end
			ST_WRITE: begin
				ci = st_ff.cur;
				nxt_st.mem.wr = 1'b0;
				nxt_st.ch[ci].srcWork = stepAddr(st_ff.ch[ci].srcWork, st_ff.ch[ci].ctl.srcStep,
					st_ff.ch[ci].ctl.srcByte);
				nxt_st.ch[ci].dstWork = stepAddr(st_ff.ch[ci].dstWork, st_ff.ch[ci].ctl.dstStep,
					st_ff.ch[ci].ctl.dstByte);
				lastItem = (st_ff.ch[ci].cntWork == 16'h0001);
				nxt_st.ch[ci].cntWork = st_ff.ch[ci].cntWork - 16'h0001;
				if (lastItem) begin
					nxt_st.ch[ci].cntWork = st_ff.ch[ci].size;
					ifgSet[ci] = 1'b1;
					nxt_st.ch[ci].ctl.enable = st_ff.ch[ci].ctl.repeatEn;
					nxt_st.ch[ci].blockAct = st_ff.ch[ci].ctl.repeatEn &&
						(st_ff.ch[ci].ctl.mode == MODE_BURST);
				end
				cont = st_ff.ch[ci].blockAct && st_ff.ch[ci].ctl.enable &&
					(!lastItem || nxt_st.ch[ci].blockAct);
				nxt_st.burstCnt = st_ff.burstCnt + 2'h1;
				if (cont && st_ff.ch[ci].ctl.mode == MODE_BURST && st_ff.burstCnt == `DCAE_BURST_LEN) begin
					nxt_st.fsm = ST_GAP;
					nxt_st.gapCnt = 2'h0;
				end else if (cont) begin
					nxt_st.fsm = ST_READ;
					nxt_st.mem.rd = 1'b1;
					nxt_st.mem.addr = nxt_st.ch[ci].srcWork;
					nxt_st.mem.byteAcc = st_ff.ch[ci].ctl.srcByte;
				end else begin
					nxt_st.fsm = ST_IDLE;
				end
			end
			default: begin
				// processor slot of burst-block; idle adds the last gap cycle
				if (int'(st_ff.gapCnt) >= `DCAE_GAP_CYC - 2) begin
					nxt_st.fsm = ST_IDLE;
				end else begin
					nxt_st.gapCnt = st_ff.gapCnt + 2'h1;
				end
			end
		endcase
		ci = avs_address[5:4];
		// register slave: one wait cycle, then answer
		if ((avs_read || avs_write) && !st_ff.ack) begin
			nxt_st.ack = 1'b1;
			nxt_st.rdata = 32'h00000000;
			if (avs_read && chanHit(avs_address)) begin
				if (rIdx == `DCAE_REG_CTL) begin
					nxt_st.rdata = 32'(st_ff.ch[ci].ctl);
				end else if (rIdx == `DCAE_REG_SRC) begin
					nxt_st.rdata = {16'h0000, st_ff.ch[ci].srcCfg};
				end else if (rIdx == `DCAE_REG_DST) begin
					nxt_st.rdata = {16'h0000, st_ff.ch[ci].dstCfg};
				end else begin
					nxt_st.rdata = {16'h0000, st_ff.ch[ci].cntWork};
				end
			end else if (avs_read && avs_address[6:4] == `DCAE_GLB_BASE) begin
				if (rIdx == `DCAE_GLB_STAT) begin
					nxt_st.rdata = 32'(st_ff.ifg);
				end else if (rIdx == `DCAE_GLB_IE) begin
					nxt_st.rdata = 32'(st_ff.ie);
				end else if (rIdx == `DCAE_GLB_CFG) begin
					nxt_st.rdata[`DCAE_CFG_RR_BIT] = st_ff.rrEn;
					nxt_st.rdata[`DCAE_CFG_BUSY] = (st_ff.fsm != ST_IDLE);
				end
			end
		end
		if (avs_write && st_ff.ack) begin
			if (chanHit(avs_address)) begin
				if (rIdx == `DCAE_REG_CTL) begin
					nxt_st.ch[ci].ctl = avs_writedata[`DCAE_CTL_W-1:0];
					if (avs_writedata[0] && !st_ff.ch[ci].ctl.enable) begin
						nxt_st.ch[ci].srcWork = st_ff.ch[ci].srcCfg;
						nxt_st.ch[ci].dstWork = st_ff.ch[ci].dstCfg;
						nxt_st.ch[ci].cntWork = st_ff.ch[ci].size;
						nxt_st.ch[ci].pend = 1'b0;
						nxt_st.ch[ci].blockAct = 1'b0;
					end else if (!avs_writedata[0]) begin
						nxt_st.ch[ci].pend = 1'b0;
						nxt_st.ch[ci].blockAct = 1'b0;
					end
				end else if (rIdx == `DCAE_REG_SRC) begin
					nxt_st.ch[ci].srcCfg = avs_writedata[15:0];
				end else if (rIdx == `DCAE_REG_DST) begin
					nxt_st.ch[ci].dstCfg = avs_writedata[15:0];
				end else begin
					nxt_st.ch[ci].size = avs_writedata[15:0];
					if (!st_ff.ch[ci].ctl.enable) begin
						nxt_st.ch[ci].cntWork = avs_writedata[15:0];
					end
				end
			end else if (avs_address[6:4] == `DCAE_GLB_BASE) begin
				if (rIdx == `DCAE_GLB_CLR) begin
					ifgClr = avs_writedata[NCH-1:0];
				end else if (rIdx == `DCAE_GLB_IE) begin
					nxt_st.ie = avs_writedata[NCH-1:0];
				end else if (rIdx == `DCAE_GLB_CFG) begin
					nxt_st.rrEn = avs_writedata[`DCAE_CFG_RR_BIT];
				end
			end
		end
		// a completion in the clearing cycle keeps its flag
		nxt_st.ifg = (st_ff.ifg & ~ifgClr) | ifgSet;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	default clocking dcaeClk @(posedge clk); endclocking
	default disable iff (reset);

	sequence readPhase;
		st_ff.mem.rd && st_ff.fsm == ST_READ;
	endsequence
	sequence writePhase;
		st_ff.mem.wr && !st_ff.mem.rd && st_ff.fsm == ST_WRITE;
	endsequence

	itemTwoCycle_a: assert property (readPhase |=> writePhase ##1 !st_ff.mem.wr)
		else $error("item did not finish in two cycles");
	busHeld_a: assert property ((st_ff.mem.rd || st_ff.mem.wr) |-> busOwn)
		else $error("memory access without bus ownership");
	zeroCount_a: assert property ($rose(st_ff.fsm == ST_READ) |-> st_ff.ch[st_ff.cur].size != 16'h0000)
		else $error("transfer started with zero count");
	upperClear_a: assert property (st_ff.fsm == ST_WRITE && st_ff.ch[st_ff.cur].ctl.srcByte |->
		st_ff.mem.wdata[15:8] == 8'h00)
		else $error("upper byte not cleared");
	lowByteWrite_a: assert property (st_ff.fsm == ST_WRITE |->
		st_ff.mem.byteAcc == st_ff.ch[st_ff.cur].ctl.dstByte &&
		st_ff.mem.wdata[7:0] == $past(memRdata[7:0]))
		else $error("destination width or data wrong");
	srcStep_a: assert property (st_ff.fsm == ST_WRITE && st_ff.ch[st_ff.cur].ctl.srcStep == STEP_INC |=>
		st_ff.ch[$past(st_ff.cur)].srcWork == $past(st_ff.ch[st_ff.cur].srcWork) +
		($past(st_ff.ch[st_ff.cur].ctl.srcByte) ? 16'h0001 : 16'h0002))
		else $error("source address step wrong");
	dstHold_a: assert property (st_ff.fsm == ST_WRITE && st_ff.ch[st_ff.cur].ctl.dstStep == STEP_HOLD |=>
		st_ff.ch[$past(st_ff.cur)].dstWork == $past(st_ff.ch[st_ff.cur].dstWork))
		else $error("fixed destination moved");
	doneReload_a: assert property (st_ff.fsm == ST_WRITE && st_ff.ch[st_ff.cur].cntWork == 16'h0001 |=>
		st_ff.ifg[$past(st_ff.cur)] && st_ff.ch[$past(st_ff.cur)].cntWork == st_ff.ch[$past(st_ff.cur)].size)
		else $error("count not reloaded or flag not set");
	fixedPrio_a: assert property (st_ff.fsm == ST_IDLE && elig[0] && !st_ff.rrEn |=> st_ff.cur == 2'h0)
		else $error("fixed priority not honoured");

	sequence burstPause;
		st_ff.fsm == ST_GAP && !busOwn ##1 st_ff.fsm == ST_IDLE;
	endsequence
	burstGap_a: assert property (st_ff.fsm == ST_WRITE && st_ff.burstCnt == `DCAE_BURST_LEN &&
		st_ff.ch[st_ff.cur].ctl.mode == MODE_BURST && st_ff.ch[st_ff.cur].blockAct &&
		st_ff.ch[st_ff.cur].ctl.enable && st_ff.ch[st_ff.cur].cntWork != 16'h0001 |=> burstPause)
		else $error("burst did not pause for the processor");
	singleItem_a: assert property (st_ff.fsm == ST_WRITE && st_ff.ch[st_ff.cur].ctl.mode == MODE_SINGLE |=>
		st_ff.fsm == ST_IDLE)
		else $error("single mode moved more than one item");
	srcFetch_a: assert property (readPhase |-> st_ff.mem.addr == st_ff.ch[st_ff.cur].srcWork &&
		st_ff.mem.byteAcc == st_ff.ch[st_ff.cur].ctl.srcByte)
		else $error("read address or width wrong");
	dstStore_a: assert property (writePhase |-> st_ff.mem.addr == st_ff.ch[st_ff.cur].dstWork)
		else $error("write address wrong");
	srcDec_a: assert property (st_ff.fsm == ST_WRITE && st_ff.ch[st_ff.cur].ctl.srcStep == STEP_DEC |=>
		st_ff.ch[$past(st_ff.cur)].srcWork == $past(st_ff.ch[st_ff.cur].srcWork) -
		($past(st_ff.ch[st_ff.cur].ctl.srcByte) ? 16'h0001 : 16'h0002))
		else $error("source address decrement wrong");
	dstDec_a: assert property (st_ff.fsm == ST_WRITE && st_ff.ch[st_ff.cur].ctl.dstStep == STEP_DEC |=>
		st_ff.ch[$past(st_ff.cur)].dstWork == $past(st_ff.ch[st_ff.cur].dstWork) -
		($past(st_ff.ch[st_ff.cur].ctl.dstByte) ? 16'h0001 : 16'h0002))
		else $error("destination address decrement wrong");
	gapFree_a: assert property (st_ff.fsm == ST_GAP |-> !busOwn && !st_ff.mem.rd && !st_ff.mem.wr)
		else $error("bus held in processor slot");

	// per-channel checks, one copy per channel
	for (genvar g = 0; g < NCH; g++) begin : gChan
		trigIgnored_a: assert property (st_ff.ch[g].blockAct && !st_ff.ch[g].pend |=> !st_ff.ch[g].pend)
			else $error("trigger taken during a block");
		levelStart_a: assert property (st_ff.fsm == ST_IDLE && st_ff.ch[g].ctl.level && trig[g] &&
			st_ff.ch[g].ctl.enable && st_ff.ch[g].size != 16'h0000 |=> st_ff.fsm == ST_READ)
			else $error("level trigger did not start a transfer");
		zeroIdle_a: assert property (st_ff.fsm == ST_IDLE && st_ff.ch[g].size == 16'h0000 |=>
			!(st_ff.fsm == ST_READ && st_ff.cur == 2'(g)))
			else $error("zero count channel started");
		flagSticky_a: assert property (st_ff.ifg[g] && !(avs_write && st_ff.ack &&
			avs_address[6:4] == `DCAE_GLB_BASE && avs_address[3:2] == `DCAE_GLB_CLR) |=> st_ff.ifg[g])
			else $error("done flag lost without a clear");
		doneDisable_a: assert property (st_ff.fsm == ST_WRITE && st_ff.cur == 2'(g) &&
			st_ff.ch[g].cntWork == 16'h0001 && !st_ff.ch[g].ctl.repeatEn && !avs_write |=> !st_ff.ch[g].ctl.enable)
			else $error("channel still enabled after its last item");
		rrNext_a: assert property (st_ff.fsm == ST_IDLE && st_ff.rrEn && elig[g] &&
			int'(st_ff.last) == (g + NCH - 1) % NCH |=> st_ff.cur == 2'(g))
			else $error("rotating priority skipped a channel");
	end
endmodule
`default_nettype wire

// file: dcae_mem_model.sv
// memory on the far side of the dma engine memory port
// assumes a 256-byte space decoded from the low address byte
`timescale 1ns/100ps
`default_nettype none
module dcae_mem_model
	import dcae_pkg::*;
(
	input  wire logic      clk,        // system clock
	input  wire dcae_mem_t mem,        // request from engine
	output logic [15:0]    memRdata    // read data
);
	logic [7:0] b [0:255];
	logic [7:0] junk = 8'ha5;
	logic [7:0] a;
	assign a = mem.addr[7:0];
	initial for (int i = 0; i < 256; i++) b[i] = 8'(i * 37 + 11);
	// unused read lanes carry noise, so zero fill by the engine is really seen
	always_comb begin
		if (mem.rd && mem.byteAcc) memRdata = {junk, b[a]};
		else if (mem.rd) memRdata = {b[a | 8'h01], b[a & 8'hfe]};
		else memRdata = {junk, ~junk};
	end
	always @(posedge clk) begin
		junk <= junk + 8'h3b;
		if (mem.wr && mem.byteAcc) b[a] <= mem.wdata[7:0];
		else if (mem.wr) begin
			b[a & 8'hfe] <= mem.wdata[7:0];
			b[a | 8'h01] <= mem.wdata[15:8];
		end
	end
endmodule
`default_nettype wire

// file: dcae_engine_test.sv
// self-checking bench of the dma addressing engine
// assumes the memory model of this folder on the memory port
`timescale 1ns/100ps
`default_nettype none
module dcae_engine_test;
	import dcae_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [6:0] adr = 7'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdat;
	logic wreq;
	logic [2:0] trig = 3'h0;
	logic [15:0] mrd;
	dcae_mem_t mem;
	logic own;
	logic irq;
	logic [31:0] q;
	logic [7:0] expMem [0:255];
	logic prevRd = 1'b0;
	int err_count = 0;
	int n_tests = 0;
	int busCyc = 0;
	always #25 clk = ~clk;
	dcae_engine #(.NCH(3)) u_dut (.clk(clk), .reset(reset), .avs_address(adr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wreq), .trig(trig),
		.memRdata(mrd), .mem(mem), .busOwn(own), .irq(irq));
	dcae_mem_model u_mem (.clk(clk), .mem(mem), .memRdata(mrd));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		if (err_count == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic guard(input int k, input int lim);
		if (k >= lim) begin
			chk(32'h1, 32'h0);
			conclude();
		end
	endtask
	task automatic waitAck();
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (wreq !== 1'b0 && k < 40);
		guard(k, 40);
	endtask
	task automatic avWr(input logic [6:0] a, input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= 1'b1;
		waitAck();
		wr <= 1'b0;
	endtask
	task automatic avRd(input logic [6:0] a);
		@(posedge clk);
		adr <= a;
		rd <= 1'b1;
		waitAck();
		q = rdat;
		rd <= 1'b0;
	endtask
	task automatic waitDone(input int ch);
		int k;
		for (k = 0; k < 60; k++) begin
			avRd(7'h40);
			if (q[ch] === 1'b1) break;
		end
		guard(k, 60);
	endtask
	function automatic logic [15:0] step(input logic [15:0] a, input logic [1:0] st, input logic byt);
		logic [15:0] inc;
		inc = byt ? 16'h0001 : 16'h0002;
		return st == 2'h1 ? a + inc : st == 2'h2 ? a - inc : a;
	endfunction
	// bus ownership and the read-then-write beat of every item
	always @(posedge clk) begin
		if (!reset && own === 1'b1) busCyc++;
		if (!reset && (mem.rd || mem.wr)) chk(own, 1);
		if (prevRd) chk(mem.wr, 1);
		prevRd <= mem.rd & ~reset;
	end
	task automatic runCase(input int ch, input logic [10:0] ctl, input logic [15:0] s, input logic [15:0] d,
		input int n, input logic [2:0] ie);
		logic [6:0] b;
		logic [15:0] v;
		int k;
		b = 7'(ch * 16);
		avWr(7'h48, {29'h0, ie});
		avWr(b + 7'h04, {16'h0, s});
		avWr(b + 7'h08, {16'h0, d});
		avWr(b + 7'h0c, n);
		avWr(b, {21'h0, ctl | 11'h001});
		expMem = u_mem.b;
		for (int i = 0; i < n; i++) begin
			v = ctl[8] ? {8'h00, expMem[s[7:0]]} : {expMem[s[7:0] | 8'h01], expMem[s[7:0] & 8'hfe]};
			expMem[ctl[9] ? d[7:0] : d[7:0] & 8'hfe] = v[7:0];
			if (!ctl[9]) expMem[d[7:0] | 8'h01] = v[15:8];
			s = step(s, ctl[5:4], ctl[8]);
			d = step(d, ctl[7:6], ctl[9]);
		end
		busCyc = 0;
		if (ctl[10]) trig[ch] <= 1'b1;
		else for (k = 0; k < (ctl[2:1] == 2'h0 ? n : 1); k++) begin
			@(posedge clk);
			trig[ch] <= 1'b1;
			@(posedge clk);
			trig[ch] <= 1'b0;
			if (ctl[2:1] == 2'h0) repeat (4) @(posedge clk);
		end
		if (n > 0) waitDone(ch);
		else repeat (20) @(posedge clk);
		trig <= 3'h0;
		avRd(7'h40);
		chk(q[ch], n != 0);
		chk(busCyc, 2 * n);
		chk(irq, n != 0 && ie[ch]);
		for (int i = 0; i < 256; i++) chk(u_mem.b[i], expMem[i]);
		avRd(b + 7'h0c);
		chk(q[15:0], n);
		avRd(b);
		if (n > 0) chk(q[0], 0);
		avWr(7'h44, 32'h7);
		avRd(7'h40);
		chk(q, 0);
		chk(irq, 0);
	endtask
	initial begin
		int k;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		avRd(7'h00);
		chk(q, 0);
		avRd(7'h48);
		chk(q, 0);
		avRd(7'h30);
		chk(q, 0);
		avWr(7'h0c, 32'h0000ffff);
		avRd(7'h0c);
		chk(q, 32'h0000ffff);
		avWr(7'h4c, 32'h0);
		runCase(0, 11'h052, 16'h0000, 16'h0080, 3, 3'h1);
		runCase(1, 11'h240, 16'h0020, 16'h00a0, 2, 3'h2);
		runCase(2, 11'h592, 16'h0040, 16'h00c6, 3, 3'h4);
		runCase(0, 11'h324, 16'h006f, 16'h00e0, 5, 3'h0);
		runCase(1, 11'h002, 16'h0010, 16'h00f0, 2, 3'h5);
		runCase(2, 11'h012, 16'h0050, 16'h00d0, 0, 3'h4);
		avWr(7'h04, 32'h0030);
		avWr(7'h14, 32'h0038);
		avWr(7'h0c, 32'h1);
		avWr(7'h1c, 32'h1);
		avWr(7'h00, 32'h3);
		avWr(7'h10, 32'h3);
		@(posedge clk);
		trig <= 3'h3;
		@(posedge clk);
		trig <= 3'h0;
		for (k = 0; k < 20 && mem.rd !== 1'b1; k++) @(posedge clk);
		guard(k, 20);
		chk(mem.addr, 16'h0030);
		waitDone(1);
		avWr(7'h44, 32'h7);
		avWr(7'h4c, 32'h1);
		avWr(7'h20, 32'h0);
		avWr(7'h24, 32'h0058);
		avWr(7'h2c, 32'h1);
		avWr(7'h10, 32'h3);
		avWr(7'h20, 32'h3);
		@(posedge clk);
		trig <= 3'h6;
		@(posedge clk);
		trig <= 3'h0;
		for (k = 0; k < 20 && mem.rd !== 1'b1; k++) @(posedge clk);
		guard(k, 20);
		chk(mem.addr, 16'h0058);
		waitDone(1);
		conclude();
	end
endmodule
`default_nettype wire
